// *** hw/ssu_pkg.sv ***
// Package with offsets, field positions, reset values and types of the bank.
package ssu_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] SYS_ADDR = 12'h230;
    localparam logic [11:0] UPD_ADDR = 12'h232;
    localparam logic [11:0] SEG_BASE = 12'hA00;
    localparam logic [11:0] SEG_LAST = 12'hA16;
    localparam int SEG_COUNT = 23;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SYS_RUNT_DIS_BIT = 3;
    localparam int SYS_ALIGN_PD_BIT = 2;
    localparam int SYS_DREF_PD_BIT = 1;
    localparam int SYS_SOFT_ALIGN_BIT = 0;
    localparam int UPD_GO_BIT = 0;
    localparam int NUM_CHAN = 4;

    // ****************************************
    // Segment list encoding
    // ****************************************
    // Block entry: byte 0 = {0, count-1}, byte 1 = address high, byte 2 = low.
    localparam logic [7:0] OP_COMMIT = 8'h80;
    localparam logic [7:0] OP_END_OF_LIST = 8'hFF;

    // Default list walks every register block, then commits, then ends.
    localparam logic [8*SEG_COUNT-1:0] SEG_RESET = {
        8'h1F, 8'h00, 8'h00,
        8'h0F, 8'h00, 8'hA0,
        8'h0F, 8'h00, 8'hF0,
        8'h0F, 8'h01, 8'h40,
        8'h0F, 8'h01, 8'h90,
        8'h01, 8'h01, 8'hE0,
        8'h03, 8'h02, 8'h30,
        OP_COMMIT,
        OP_END_OF_LIST
    };

    localparam logic [7:0] SYS_RESET = 8'h00;

    typedef struct packed {
        logic runt_dis;
        logic align_pd;
        logic dref_pd;
        logic soft_align;
    } ssu_sys_s;

endpackage : ssu_pkg

// *** hw/ssu_regs.sv ***
// System alignment, update and memory buffer segment register bank.
//
// Function
// - Bit 3 set disables runt-pulse suppression.
// - Bit 2 set powers down alignment circuitry.
// - Bit 1 set powers down distribution reference.
// - Soft alignment bit high holds selected outputs static.
// - Soft alignment falling edge triggers alignment event.
// - Soft bit polarity opposite to active-low pin.
// - Writing update bit copies buffers to active.
// - Copy happens on next clock edge.
// - Update bit clears itself after transfer.
// - Segments hold block start address and count.
// - Segments also hold commit and end opcodes.
// - Segment reset list transfers everything, then commits.
// - Channels ignoring alignment are unaffected by events.
module ssu_regs (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic hit_o,
    input wire logic align_n_i,
    input wire logic mem_commit_i,
    input wire logic [ssu_pkg::NUM_CHAN-1:0] chan_ignore_i,
    output logic runt_supp_en_o,
    output logic align_pd_o,
    output logic dref_pd_o,
    output logic [ssu_pkg::NUM_CHAN-1:0] chan_hold_o,
    output logic [ssu_pkg::NUM_CHAN-1:0] chan_align_o,
    output logic update_o,
    output logic [8*ssu_pkg::SEG_COUNT-1:0] seg_list_o
);

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic is_seg(input logic [11:0] a);
        is_seg = (a >= ssu_pkg::SEG_BASE) && (a <= ssu_pkg::SEG_LAST);
    endfunction : is_seg

    function automatic logic [4:0] seg_idx(input logic [11:0] a);
        logic [11:0] d;
        d = a - ssu_pkg::SEG_BASE;
        seg_idx = d[4:0];
    endfunction : seg_idx

    logic wr_sys;
    logic wr_upd;
    logic wr_seg;
    logic hit;

    assign wr_sys = wr_en_i && (addr_i == ssu_pkg::SYS_ADDR);
    assign wr_upd = wr_en_i && (addr_i == ssu_pkg::UPD_ADDR);
    assign wr_seg = wr_en_i && is_seg(addr_i);
    assign hit = (addr_i == ssu_pkg::SYS_ADDR)
        || (addr_i == ssu_pkg::UPD_ADDR) || is_seg(addr_i);
    assign hit_o = hit;

    // ****************************************
    // Field packing
    // ****************************************
    function automatic ssu_pkg::ssu_sys_s to_sys(input logic [7:0] d);
        ssu_pkg::ssu_sys_s s;
        s.runt_dis = d[ssu_pkg::SYS_RUNT_DIS_BIT];
        s.align_pd = d[ssu_pkg::SYS_ALIGN_PD_BIT];
        s.dref_pd = d[ssu_pkg::SYS_DREF_PD_BIT];
        s.soft_align = d[ssu_pkg::SYS_SOFT_ALIGN_BIT];
        to_sys = s;
    endfunction : to_sys

    function automatic logic [7:0] from_sys(input ssu_pkg::ssu_sys_s s);
        logic [7:0] d;
        d = 8'h00;
        d[ssu_pkg::SYS_RUNT_DIS_BIT] = s.runt_dis;
        d[ssu_pkg::SYS_ALIGN_PD_BIT] = s.align_pd;
        d[ssu_pkg::SYS_DREF_PD_BIT] = s.dref_pd;
        d[ssu_pkg::SYS_SOFT_ALIGN_BIT] = s.soft_align;
        from_sys = d;
    endfunction : from_sys

    // Channels that ignore alignment are masked out of every hold and event.
    function automatic logic [ssu_pkg::NUM_CHAN-1:0] chan_mask(
        input logic en,
        input logic [ssu_pkg::NUM_CHAN-1:0] ignore
    );
        chan_mask = {ssu_pkg::NUM_CHAN{en}} & ~ignore;
    endfunction : chan_mask

    // ****************************************
    // Buffer and active system register
    // ****************************************
    // Two copies of the system register: the host writes the buffer, the
    // outputs follow the active copy.
    ssu_pkg::ssu_sys_s sys_buf_r;
    ssu_pkg::ssu_sys_s sys_act_r;
    ssu_pkg::ssu_sys_s sys_act_nxt;
    logic upd_r;
    logic upd_nxt;
    logic upd_set;
    logic copy;

    // A write only reaches the buffer; behaviour changes at the copy.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sys_buf_r <= to_sys(ssu_pkg::SYS_RESET);
        end else if (ce_i && wr_sys) begin
            sys_buf_r <= to_sys(wdata_i);
        end
    end

    // ****************************************
    // Update bit
    // ****************************************
    assign upd_set = wr_upd && wdata_i[ssu_pkg::UPD_GO_BIT];

    // The bit is set on the write edge and copies on the edge after, so
    // the copy lands on the next clock after it is set. A new set in the
    // copy cycle wins over the self-clear, so no request is lost.
    always_comb begin
        if (upd_set) begin
            upd_nxt = 1'b1;
        end else if (upd_r) begin
            upd_nxt = 1'b0;
        end else begin
            upd_nxt = upd_r;
        end
    end

    // With the clock enable low the pending copy waits, so a frozen bank
    // never loses an update.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            upd_r <= 1'b0;
        end else if (ce_i) begin
            upd_r <= upd_nxt;
        end
    end

    // The memory controller's commit opcode copies the buffers as well.
    assign copy = upd_r || mem_commit_i;

    always_comb begin
        if (copy) begin
            sys_act_nxt = sys_buf_r;
        end else begin
            sys_act_nxt = sys_act_r;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sys_act_r <= to_sys(ssu_pkg::SYS_RESET);
        end else if (ce_i) begin
            sys_act_r <= sys_act_nxt;
        end
    end

    assign update_o = upd_r;

    // ****************************************
    // Power and runt controls
    // ****************************************
    logic runt_en_r;
    logic align_pd_r;
    logic dref_pd_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            runt_en_r <= !ssu_pkg::SYS_RESET[ssu_pkg::SYS_RUNT_DIS_BIT];
            align_pd_r <= ssu_pkg::SYS_RESET[ssu_pkg::SYS_ALIGN_PD_BIT];
            dref_pd_r <= ssu_pkg::SYS_RESET[ssu_pkg::SYS_DREF_PD_BIT];
        end else if (ce_i) begin
            runt_en_r <= !sys_act_nxt.runt_dis;
            align_pd_r <= sys_act_nxt.align_pd;
            dref_pd_r <= sys_act_nxt.dref_pd;
        end
    end

    assign runt_supp_en_o = runt_en_r;
    assign align_pd_o = align_pd_r;
    assign dref_pd_o = dref_pd_r;

    // ****************************************
    // Alignment hold and event
    // ****************************************
    logic align_low_r;
    logic align_low_nxt;
    logic align_fall;
    logic [ssu_pkg::NUM_CHAN-1:0] hold_r;
    logic [ssu_pkg::NUM_CHAN-1:0] event_r;

    // Soft bit high acts as the pin pulled low, so both merge into one level.
    // A hold that ends through the pin and the soft bit at once still gives
    // a single event, since both feed that one level.
    assign align_low_nxt = !align_n_i || sys_act_nxt.soft_align;
    assign align_fall = align_low_r && !align_low_nxt;

    // Reset leaves the level released, matching the pin's idle high, so no
    // false event follows reset.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            align_low_r <= 1'b0;
        end else if (ce_i) begin
            align_low_r <= align_low_nxt;
        end
    end

    // Hold is registered from the next level so it moves on the copy edge.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hold_r <= '0;
        end else if (ce_i) begin
            hold_r <= chan_mask(align_low_nxt, chan_ignore_i);
        end
    end

    // One-cycle event pulse; a frozen clock enable stretches it.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            event_r <= '0;
        end else if (ce_i) begin
            event_r <= chan_mask(align_fall, chan_ignore_i);
        end
    end

    assign chan_hold_o = hold_r;
    assign chan_align_o = event_r;

    // ****************************************
    // Memory buffer segment bank
    // ****************************************
    logic [7:0] seg_r [0:ssu_pkg::SEG_COUNT-1];

    // Entry 0 sits in the top byte of the packed default list.
    function automatic logic [7:0] seg_default(input int i);
        seg_default = ssu_pkg::SEG_RESET[8*(ssu_pkg::SEG_COUNT-1-i) +: 8];
    endfunction : seg_default

    // The controller reads the list live, so segment writes need no update.
    // The decode bounds the index to the list, so it never runs past the
    // array.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < ssu_pkg::SEG_COUNT; i++) begin
                seg_r[i] <= seg_default(i);
            end
        end else if (ce_i && wr_seg) begin
            seg_r[seg_idx(addr_i)] <= wdata_i;
        end
    end

    always_comb begin
        seg_list_o = '0;
        for (int i = 0; i < ssu_pkg::SEG_COUNT; i++) begin
            seg_list_o[8*(ssu_pkg::SEG_COUNT-1-i) +: 8] = seg_r[i];
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [7:0] rd_val;
    logic [7:0] rdata_r;
    logic rvalid_r;

    // Reads return the buffered copy, which is what the host last wrote.
    // Addresses outside the map read as zero and raise no valid flag.
    always_comb begin
        rd_val = 8'h00;
        if (addr_i == ssu_pkg::SYS_ADDR) begin
            rd_val = from_sys(sys_buf_r);
        end else if (addr_i == ssu_pkg::UPD_ADDR) begin
            rd_val[ssu_pkg::UPD_GO_BIT] = upd_r;
        end else if (is_seg(addr_i)) begin
            rd_val = seg_r[seg_idx(addr_i)];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
        end else if (ce_i && rd_en_i) begin
            rdata_r <= rd_val;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rvalid_r <= 1'b0;
        end else if (ce_i) begin
            rvalid_r <= rd_en_i && hit;
        end
    end

    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;

endmodule : ssu_regs

// *** tb/ssu_regs_chk.sv ***
// Checker that ties the bank's outputs to their causes.
module ssu_regs_chk (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic mem_commit_i,
    input wire logic update_o,
    input wire logic runt_supp_en_o,
    input wire logic [3:0] chan_hold_o,
    input wire logic [3:0] chan_align_o,
    input wire logic [3:0] chan_ignore_i,
    input wire logic [183:0] seg_list_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_upd_self_clear: assert property ((update_o && ce_i
        && !(wr_en_i && addr_i == ssu_pkg::UPD_ADDR)) |=> !update_o)
        else $error("update bit stayed set");
    a_upd_set_seen: assert property ((ce_i && wr_en_i
        && addr_i == ssu_pkg::UPD_ADDR && wdata_i[0]) |=> update_o)
        else $error("update bit not set");
    a_hold_ignore: assert property ((chan_hold_o & chan_ignore_i) == 4'h0)
        else $error("ignored channel held");
    a_seg_reset_list: assert property ($rose(rst_n_i) |->
        seg_list_o == ssu_pkg::SEG_RESET) else $error("bad segment list");
    a_runt_buffered: assert property ($changed(runt_supp_en_o) |->
        update_o || $past(update_o) || $past(mem_commit_i))
        else $error("runt moved early");
    a_ignore_align: assert property ((chan_align_o & chan_ignore_i) == 4'h0)
        else $error("ignored channel aligned");
    cover property (update_o);
    cover property (chan_align_o[0]);
    cover property ($fell(runt_supp_en_o));
endmodule : ssu_regs_chk
bind ssu_regs ssu_regs_chk i_chk (.*);

// *** tb/ssu_host.sv ***
// Host model that writes the bank one byte at a time.
module ssu_host (
    input wire logic clk_i,
    output logic [22:0] bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle keeps the clock enable high so a pending update is not frozen.
    localparam logic [22:0] IDLE = 23'h200000;
    initial bus_o = IDLE;
    // Strobe held for one edge, then released so writes never merge.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i) #1 bus_o = {3'b011, a, d};
        @(posedge clk_i) #1 bus_o = IDLE;
    endtask : wr
    // Read data stands from the sampling edge until the next one.
    task automatic rd(input logic [11:0] a);
        @(posedge clk_i) #1 bus_o = {3'b110, a, 8'h00};
        @(posedge clk_i) #1 bus_o = IDLE;
    endtask : rd
endmodule : ssu_host

// *** tb/ssu_regs_tb.sv ***
// Bench that writes the bank and checks its active outputs.
module ssu_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, rst_n_i = 0, runt, apd, dpd, upd;
    logic rv;
    logic [7:0] rdv;
    logic [22:0] bus;
    logic [3:0] hold;
    logic [3:0] align;
    logic [183:0] seg;
    int error_cnt = 0, cmp_count = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    ssu_host i_host (.clk_i(ref_clk_i), .bus_o(bus));
    ssu_regs i_dut (.ref_clk_i, .rst_n_i, .ce_i(bus[21]), .wr_en_i(bus[20]),
        .rd_en_i(bus[22]), .addr_i(bus[19:8]), .wdata_i(bus[7:0]),
        .rdata_o(rdv), .rvalid_o(rv), .hit_o(), .align_n_i(1'b1),
        .mem_commit_i(1'b0), .chan_ignore_i(4'h2), .runt_supp_en_o(runt),
        .align_pd_o(apd), .dref_pd_o(dpd), .chan_hold_o(hold),
        .chan_align_o(align),
        .update_o(upd), .seg_list_o(seg));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial begin
        #13 rst_n_i = 1;
        chk({runt, seg == ssu_pkg::SEG_RESET}, 8'h03);
        chk({hold, align}, 8'h00);
        i_host.rd(ssu_pkg::SEG_BASE);
        chk({7'h00, rv}, 8'h01);
        chk(rdv, 8'h1F);
        i_host.rd(ssu_pkg::SEG_LAST - 12'h001);
        chk(rdv, ssu_pkg::OP_COMMIT);
        i_host.rd(ssu_pkg::SEG_LAST);
        chk(rdv, ssu_pkg::OP_END_OF_LIST);
        i_host.wr(ssu_pkg::SEG_BASE + 12'h003, 8'h5A);
        i_host.rd(ssu_pkg::SEG_BASE + 12'h003);
        chk(rdv, 8'h5A);
        chk(seg[159:152], 8'h5A);
        i_host.wr(ssu_pkg::SYS_ADDR, 8'h0E);
        chk({runt, apd, dpd}, 8'h04);
        i_host.rd(ssu_pkg::SYS_ADDR);
        chk(rdv, 8'h0E);
        i_host.wr(ssu_pkg::UPD_ADDR, 8'h01);
        chk({7'h00, upd}, 8'h01);
        @(posedge ref_clk_i) #1;
        chk({runt, apd, dpd, upd}, 8'h06);
        i_host.wr(ssu_pkg::SYS_ADDR, 8'h01);
        i_host.wr(ssu_pkg::UPD_ADDR, 8'h01);
        @(posedge ref_clk_i) #1;
        chk(hold, 8'h0D);
        chk(align, 8'h00);
        i_host.wr(ssu_pkg::SYS_ADDR, 8'h00);
        i_host.wr(ssu_pkg::UPD_ADDR, 8'h01);
        @(posedge ref_clk_i) #1;
        chk({hold, align}, 8'h0D);
        $display("alignment and update test ended");
        test_done;
    end
endmodule : ssu_regs_tb
